// ### lmr_limit_monitor.sv
// Paged limit, temperature calibration and turn-on timing bank, two channels.
// Assumes measurement inputs come from logic on ref_clk; the command port is
// fed by a serial front end on the same clock.
//
// Behaviour
// [R1] Overcurrent fault limit rounds up to next sense threshold over sense gain.
// [R2] Low range offers eight thresholds from 25 mV to 50 mV.
// [R3] High range offers eight thresholds from 37.5 mV to 75 mV.
// [R4] Range select bit: 0 picks low range, 1 picks high range.
// [R5] Peak current limit operation flags an output overcurrent fault.
// [R6] Sense gain scales by one plus coefficient times temperature minus 27.
// [R7] Overcurrent fault detection is suppressed during rise and fall ramps.
// [R8] Average current reading is compared against the warning limit.
// [R9] Current warning sets catch-all, current word bit, warn bit, alert.
// [R10] Measured-limit flags may lag the condition by up to 90 ms.
// [R11] Temperature slope is integer N scaled by two to the minus fourteen.
// [R12] Temperature starts from -273.15 and adds the programmed offset.
// [R13] Overtemperature fault when temperature exceeds its fault limit.
// [R14] Overtemperature warning sets temperature bits and asserts alert.
// [R15] Undertemperature fault when temperature falls below its limit.
// [R16] Without a sensor the host programs -275 C and ignores the fault.
// [R17] Start waits the turn-on delay in ms, up to 83 s, before rising.
// [R18] Output ramps over the rise time in discontinuous conduction.
// [R19] Rise below 0.25 ms bypasses digital slope; slope never over 4 V/ms.
// [R20] Turn-on timeout limit; zero means unlimited, up to 83 s.
// [R21] Set-point changes slew at the programmed rate, not at turn-on.
// [R22] Settings travel as 16-bit words, 5-bit exponent, 11-bit mantissa.
// [R23] Each channel keeps its own copy, selected by the active page.
`default_nettype none
module lmr_limit_monitor #(
  parameter int unsigned MS_CYCLES = lmr_pkg::LMR_MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire lmr_pkg::lmr_host_req_t host_req,
  output lmr_pkg::lmr_host_rsp_t host_rsp,
  input wire logic meas_valid,
  input wire lmr_pkg::lmr_chan_in_t [1:0] chan_in,
  output lmr_pkg::lmr_chan_out_t [1:0] chan_out,
  output logic alert_out,
  output logic alert_oe_n
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  lmr_pkg::lmr_state_t state_reg;
  lmr_pkg::lmr_state_t state_next;
  lmr_pkg::lmr_chan_st_t [1:0] ch_reg;
  logic ms_tick;

  assign ch_reg[0] = state_reg.ch[0];
  assign ch_reg[1] = state_reg.ch[1];
  assign ms_tick = (state_reg.div_cnt == 17'(MS_CYCLES - 1));

  function automatic logic [4:0] lmr_cmd_slot(input logic [7:0] cmd);
    logic [4:0] r;
    r = 5'h1F;
    for (int k = 0; k < lmr_pkg::LMR_NREG; k++) begin
      if (lmr_pkg::LMR_CMD_CODES[k] == cmd) begin
        r = 5'(k);
      end
    end
    return r;
  endfunction : lmr_cmd_slot

  function automatic logic [7:0] lmr_status_byte(input lmr_pkg::lmr_chan_st_t c);
    logic [7:0] b;
    b = 8'h00;
    b[lmr_pkg::LMR_SB_CATCH_ALL] = c.output_current_status[lmr_pkg::LMR_SI_OC_WARN];
    b[lmr_pkg::LMR_SB_TEMP] = |c.status_temp;
    b[lmr_pkg::LMR_SB_IOUT_OC] = c.output_current_status[lmr_pkg::LMR_SI_OC_FAULT];
    return b;
  endfunction : lmr_status_byte

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    lmr_pkg::lmr_chan_st_t c;
    logic signed [63:0] gain;
    logic signed [63:0] corr;
    logic signed [63:0] prod;
    logic signed [63:0] meas;
    logic signed [63:0] temp;
    logic signed [63:0] tgt;
    logic signed [63:0] rate;
    logic signed [15:0] slope;
    logic [7:0] clr_iout;
    logic [7:0] clr_temp;
    logic [4:0] slot;
    logic hit;
    logic ramping;
    c = '0;
    gain = '0;
    corr = '0;
    prod = '0;
    meas = '0;
    temp = '0;
    tgt = '0;
    rate = '0;
    slope = '0;
    clr_iout = '0;
    clr_temp = '0;
    hit = 1'b0;
    ramping = 1'b0;
    slot = lmr_cmd_slot(host_req.cmd);
    state_next = state_reg;
    state_next.div_cnt = ms_tick ? 17'h0_0000 : state_reg.div_cnt + 17'h0_0001;
    state_next.rsp = '0;

    for (int i = 0; i < lmr_pkg::LMR_NCH; i++) begin
      c = ch_reg[i];
      hit = (host_req.page == 8'(i)) || (host_req.page == lmr_pkg::LMR_PAGE_ALL); // see [R23]
      clr_iout = '0;
      clr_temp = '0;
      if (host_req.wr && hit) begin
        if (slot != 5'h1F) begin
          c.regs[slot] = host_req.wdata; // see [R22]
        end else if (host_req.cmd == lmr_pkg::LMR_CMD_OUTPUT_CURRENT_STATUS) begin
          clr_iout = host_req.wdata[7:0];
        end else if (host_req.cmd == lmr_pkg::LMR_CMD_STATUS_TEMP) begin
          clr_temp = host_req.wdata[7:0];
        end
      end
      // Clear first so an event in the same cycle still lands
      c.output_current_status = c.output_current_status & ~clr_iout;
      c.status_temp = c.status_temp & ~clr_temp;

      // Temperature-compensated sense gain, then rounded-up threshold
      gain = lmr_pkg::lmr_lin_q8(chan_in[i].current_sense_gain);
      // Divide by a million last: dividing first throws away most of a small gain
      corr = gain * 64'($signed(chan_in[i].sense_gain_temp_coefficient));
      corr = ((corr * (64'(ch_reg[i].ext_temp_q8) - lmr_pkg::LMR_TC_NOM_Q8)) >>> 8)
             / lmr_pkg::LMR_PPM_DIV; // see [R6]
      prod = lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_OC_FAULT]) * (gain + corr) * 10;
      c.oc_thresh = lmr_pkg::LMR_OC_TAB[chan_in[i].high_range][7]; // see [R4]
      for (int k = 7; k >= 0; k--) begin
        if ((64'(lmr_pkg::LMR_OC_TAB[chan_in[i].high_range][k]) <<< 16) >= prod) begin
          c.oc_thresh = lmr_pkg::LMR_OC_TAB[chan_in[i].high_range][k]; // see [R1] [R2] [R3]
        end
      end

      ramping = (ch_reg[i].seq == lmr_pkg::LMR_SEQ_RISE) || chan_in[i].ramp_down;
      if (chan_in[i].peak_limit && !ramping) begin // see [R7]
        c.output_current_status[lmr_pkg::LMR_SI_OC_FAULT] = 1'b1; // see [R5]
      end

      // ADC-driven limits are judged on the sample they arrive with
      if (meas_valid) begin // see [R10]
        meas = lmr_pkg::lmr_lin_q8(chan_in[i].average_output_current_reading);
        if (meas > lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_OC_WARN])) begin // see [R8]
          c.output_current_status[lmr_pkg::LMR_SI_OC_WARN] = 1'b1; // see [R9]
        end
        // Slopes below the valid floor are held at the floor
        slope = $signed(c.regs[lmr_pkg::R_TEMP_SLOPE]);
        if (slope < lmr_pkg::LMR_SLOPE_MIN) begin
          slope = lmr_pkg::LMR_SLOPE_MIN;
        end
        temp = (64'(chan_in[i].temp_sense_q8) * 64'(slope)) >>> lmr_pkg::LMR_SLOPE_SHIFT; // see [R11]
        temp = temp + lmr_pkg::LMR_ABS_ZERO_Q8
               + lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_TEMP_SHIFT]); // see [R12]
        c.ext_temp_q8 = 32'(temp);
        if (temp > lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_OT_FAULT])) begin
          c.status_temp[lmr_pkg::LMR_ST_OT_FAULT] = 1'b1; // see [R13]
        end
        if (temp > lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_OT_WARN])) begin
          c.status_temp[lmr_pkg::LMR_ST_OT_WARN] = 1'b1; // see [R14]
        end
        if (temp < lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_UT_FAULT])) begin
          c.status_temp[lmr_pkg::LMR_ST_UT_FAULT] = 1'b1; // see [R15]
        end
      end

      // Turn-on sequencer, counting in Q8 milliseconds
      tgt = 64'(chan_in[i].output_voltage_setpoint) <<< 8;
      if (!chan_in[i].start) begin
        c.seq = lmr_pkg::LMR_SEQ_OFF;
        c.ref_q8 = '0;
        c.cnt_q8 = '0;
        c.ton_q8 = '0;
      end else begin
        unique case (ch_reg[i].seq)
          lmr_pkg::LMR_SEQ_OFF: begin
            c.seq = lmr_pkg::LMR_SEQ_DELAY;
            c.cnt_q8 = '0;
            c.ton_q8 = '0;
            c.ton_fault = 1'b0;
          end
          lmr_pkg::LMR_SEQ_DELAY: begin
            if (64'(ch_reg[i].cnt_q8) >= lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_TURN_ON_DELAY])) begin
              c.seq = lmr_pkg::LMR_SEQ_RISE; // see [R17]
              c.cnt_q8 = '0;
              c.bypass = lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_TURN_ON_RAMP_TIME])
                         < lmr_pkg::LMR_RISE_BYPASS_Q8; // see [R19]
              if (c.bypass) begin
                c.step_q8 = 32'(lmr_pkg::LMR_SLOPE_MAX_Q8);
              end else begin
                rate = (tgt <<< 8) / lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_TURN_ON_RAMP_TIME]);
                if (rate > lmr_pkg::LMR_SLOPE_MAX_Q8) begin
                  rate = lmr_pkg::LMR_SLOPE_MAX_Q8; // see [R19]
                end
                c.step_q8 = 32'(rate);
              end
            end else if (ms_tick) begin
              c.cnt_q8 = ch_reg[i].cnt_q8 + lmr_pkg::LMR_MS_Q8;
            end
          end
          lmr_pkg::LMR_SEQ_RISE: begin
            // Analog loop owns a bypassed ramp; reference jumps to target
            if (ch_reg[i].bypass || (64'(ch_reg[i].ref_q8) >= tgt)) begin
              c.seq = lmr_pkg::LMR_SEQ_ON;
              c.ref_q8 = 32'(tgt);
            end else if (ms_tick) begin
              c.ref_q8 = ch_reg[i].ref_q8 + ch_reg[i].step_q8; // see [R18]
            end
          end
          lmr_pkg::LMR_SEQ_ON: begin
            rate = lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_SLEW]) * lmr_pkg::LMR_MV_PER_V;
            if (ms_tick) begin // see [R21]
              if (64'(ch_reg[i].ref_q8) + rate < tgt) begin
                c.ref_q8 = 32'(64'(ch_reg[i].ref_q8) + rate);
              end else if (64'(ch_reg[i].ref_q8) - rate > tgt) begin
                c.ref_q8 = 32'(64'(ch_reg[i].ref_q8) - rate);
              end else begin
                c.ref_q8 = 32'(tgt);
              end
            end
          end
        endcase
        // Timeout runs from the start of the rise until the output is up
        if ((ch_reg[i].seq == lmr_pkg::LMR_SEQ_RISE || ch_reg[i].seq == lmr_pkg::LMR_SEQ_ON)
            && !chan_in[i].above_uv && ms_tick) begin
          c.ton_q8 = ch_reg[i].ton_q8 + lmr_pkg::LMR_MS_Q8;
        end
        if (lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_TON_MAX]) != 64'sd0 && !chan_in[i].above_uv
            && 64'(ch_reg[i].ton_q8) >= lmr_pkg::lmr_lin_q8(c.regs[lmr_pkg::R_TON_MAX])) begin
          c.ton_fault = 1'b1; // see [R20]
        end
      end
      state_next.ch[i] = c;
    end

    // Reads come from channel 0 when all pages are addressed
    if (host_req.rd || host_req.wr) begin
      if (host_req.page > 8'h01 && host_req.page != lmr_pkg::LMR_PAGE_ALL) begin
        state_next.rsp.nack = 1'b1;
      end else if (host_req.rd) begin
        c = ch_reg[host_req.page[0] && host_req.page != lmr_pkg::LMR_PAGE_ALL];
        state_next.rsp.rvalid = 1'b1;
        if (slot != 5'h1F) begin
          state_next.rsp.rdata = c.regs[slot];
        end else if (host_req.cmd == lmr_pkg::LMR_CMD_STATUS_BYTE) begin
          state_next.rsp.rdata = {8'h00, lmr_status_byte(c)};
        end else if (host_req.cmd == lmr_pkg::LMR_CMD_STATUS_WORD) begin
          state_next.rsp.rdata = {8'h00, lmr_status_byte(c)};
          state_next.rsp.rdata[lmr_pkg::LMR_SW_IOUT] = |c.output_current_status; // see [R9]
        end else if (host_req.cmd == lmr_pkg::LMR_CMD_OUTPUT_CURRENT_STATUS) begin
          state_next.rsp.rdata = {8'h00, c.output_current_status};
        end else if (host_req.cmd == lmr_pkg::LMR_CMD_STATUS_TEMP) begin
          state_next.rsp.rdata = {8'h00, c.status_temp};
        end else begin
          state_next.rsp.rvalid = 1'b0;
          state_next.rsp.nack = 1'b1;
        end
      end else if (slot == 5'h1F && host_req.cmd != lmr_pkg::LMR_CMD_OUTPUT_CURRENT_STATUS
                   && host_req.cmd != lmr_pkg::LMR_CMD_STATUS_TEMP) begin
        state_next.rsp.nack = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= '0;
      for (int i = 0; i < lmr_pkg::LMR_NCH; i++) begin
        state_reg.ch[i][$bits(lmr_pkg::lmr_chan_st_t)-1 -: 1] <= 1'b0;
        state_reg.ch[i][175:0] <= lmr_pkg::LMR_RESET_VALS;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < lmr_pkg::LMR_NCH; i++) begin
      chan_out[i].dcm = (ch_reg[i].seq == lmr_pkg::LMR_SEQ_RISE); // see [R18]
      chan_out[i].rise_bypass = ch_reg[i].bypass;
      chan_out[i].oc_fault = ch_reg[i].output_current_status[lmr_pkg::LMR_SI_OC_FAULT];
      chan_out[i].ot_fault = ch_reg[i].status_temp[lmr_pkg::LMR_ST_OT_FAULT];
      chan_out[i].ut_fault = ch_reg[i].status_temp[lmr_pkg::LMR_ST_UT_FAULT];
      chan_out[i].ton_max_fault = ch_reg[i].ton_fault;
      chan_out[i].oc_thresh = ch_reg[i].oc_thresh;
      chan_out[i].ref_q8 = ch_reg[i].ref_q8;
      chan_out[i].ext_temp_q8 = ch_reg[i].ext_temp_q8;
    end
  end
  assign host_rsp = state_reg.rsp;
  // Open-drain alert: pin pulled low while any flag stands
  assign alert_out = 1'b0;
  assign alert_oe_n = ~(|{ch_reg[0].output_current_status, ch_reg[0].status_temp, ch_reg[0].ton_fault,
                          ch_reg[1].output_current_status, ch_reg[1].status_temp, ch_reg[1].ton_fault});

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_OC_SUPPRESS: assert property ( // see [R7]
    (ch_reg[0].seq == lmr_pkg::LMR_SEQ_RISE || chan_in[0].ramp_down)
    && !ch_reg[0].output_current_status[lmr_pkg::LMR_SI_OC_FAULT]
    |=> !ch_reg[0].output_current_status[lmr_pkg::LMR_SI_OC_FAULT])
    else $error("overcurrent fault raised during a ramp");
  AST_OC_FAULT: assert property ( // see [R5]
    chan_in[0].peak_limit && !chan_in[0].ramp_down && ch_reg[0].seq == lmr_pkg::LMR_SEQ_ON
    |=> chan_out[0].oc_fault ##1 !alert_oe_n)
    else $error("peak limit did not raise overcurrent fault and alert");
  AST_RANGE: assert property ( // see [R4]
    !sys_rst |=> (chan_out[1].oc_thresh >= ($past(chan_in[1].high_range) ? 10'd375 : 10'd250))
    && (chan_out[1].oc_thresh <= ($past(chan_in[1].high_range) ? 10'd750 : 10'd500)))
    else $error("threshold outside the selected range");
  AST_OC_WARN: assert property ( // see [R8]
    meas_valid && lmr_pkg::lmr_lin_q8(chan_in[0].average_output_current_reading)
    > lmr_pkg::lmr_lin_q8(ch_reg[0].regs[lmr_pkg::R_OC_WARN]) && !host_req.wr
    |=> ch_reg[0].output_current_status[lmr_pkg::LMR_SI_OC_WARN] && !alert_oe_n)
    else $error("current warning not flagged");
  AST_NO_WARN_WITHOUT_SAMPLE: assert property ( // see [R10]
    !meas_valid && !ch_reg[1].status_temp[lmr_pkg::LMR_ST_OT_WARN]
    |=> !ch_reg[1].status_temp[lmr_pkg::LMR_ST_OT_WARN])
    else $error("temperature warning set without a sample");
  AST_DELAY_DONE: assert property ( // see [R17]
    chan_in[0].start && ch_reg[0].seq == lmr_pkg::LMR_SEQ_DELAY
    && 64'(ch_reg[0].cnt_q8) >= lmr_pkg::lmr_lin_q8(ch_reg[0].regs[lmr_pkg::R_TURN_ON_DELAY])
    ##1 chan_in[0].start |-> chan_out[0].dcm)
    else $error("rise did not follow the turn-on delay");
  AST_DCM_RISE: assert property ( // see [R18]
    $rose(chan_out[0].dcm) |-> $past(ch_reg[0].seq == lmr_pkg::LMR_SEQ_DELAY))
    else $error("discontinuous mode outside rise");
  AST_SLOPE_CAP: assert property ( // see [R19]
    ch_reg[0].seq == lmr_pkg::LMR_SEQ_RISE |-> 64'(ch_reg[0].step_q8) <= lmr_pkg::LMR_SLOPE_MAX_Q8)
    else $error("rise step above the slope ceiling");
  AST_TON_UNLIMITED: assert property ( // see [R20]
    !host_req.wr && ch_reg[1].regs[lmr_pkg::R_TON_MAX][10:0] == 11'h000
    && !ch_reg[1].ton_fault
    |=> !ch_reg[1].ton_fault)
    else $error("timeout fault with an unlimited setting");

  COV_RISE_TO_ON: cover property (
    ch_reg[0].seq == lmr_pkg::LMR_SEQ_RISE ##1 ch_reg[0].seq == lmr_pkg::LMR_SEQ_ON);
  COV_OC_WARN: cover property ($rose(ch_reg[0].output_current_status[lmr_pkg::LMR_SI_OC_WARN]));
  COV_OT_FAULT: cover property ($rose(chan_out[1].ot_fault));
  COV_TON_FAULT: cover property ($rose(chan_out[0].ton_max_fault));
endmodule : lmr_limit_monitor
`default_nettype wire

// ### lmr_pkg.sv
// Package for the per-channel limit, temperature and ramp timing bank.
// Assumes one 125 MHz clock and a two-channel, paged command port.
`default_nettype none
package lmr_pkg;
  // ----------------------------------------------------------------
  // Command codes and register slots
  // ----------------------------------------------------------------
  localparam int LMR_NREG = 11;
  localparam int LMR_NCH = 2;
  localparam int R_SLEW = 0;
  localparam int R_OC_FAULT = 1;
  localparam int R_OC_WARN = 2;
  localparam int R_OT_FAULT = 3;
  localparam int R_OT_WARN = 4;
  localparam int R_UT_FAULT = 5;
  localparam int R_TURN_ON_DELAY = 6;
  localparam int R_TURN_ON_RAMP_TIME = 7;
  localparam int R_TON_MAX = 8;
  localparam int R_TEMP_SLOPE = 9;
  localparam int R_TEMP_SHIFT = 10;
  localparam logic [10:0][7:0] LMR_CMD_CODES = {8'hF9, 8'hF8, 8'h62, 8'h61, 8'h60,
    8'h53, 8'h51, 8'h4F, 8'h4A, 8'h46, 8'h27};
  localparam logic [10:0][15:0] LMR_RESET_VALS = {16'h8000, 16'h4000, 16'hD280,
    16'hD200, 16'h8000, 16'hE580, 16'hEAA8, 16'hEB20, 16'hDA80, 16'hDBB8, 16'hAA00};
  localparam logic [7:0] LMR_CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] LMR_CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] LMR_CMD_OUTPUT_CURRENT_STATUS = 8'h7B;
  localparam logic [7:0] LMR_CMD_STATUS_TEMP = 8'h7D;
  localparam logic [7:0] LMR_PAGE_ALL = 8'hFF;
  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int LMR_SB_CATCH_ALL = 0;
  localparam int LMR_SB_TEMP = 2;
  localparam int LMR_SB_IOUT_OC = 4;
  localparam int LMR_SW_IOUT = 14;
  localparam int LMR_SI_OC_FAULT = 7;
  localparam int LMR_SI_OC_WARN = 5;
  localparam int LMR_ST_OT_FAULT = 7;
  localparam int LMR_ST_OT_WARN = 6;
  localparam int LMR_ST_UT_FAULT = 4;
  // ----------------------------------------------------------------
  // Thresholds and arithmetic constants
  // ----------------------------------------------------------------
  // Sense thresholds in tenths of a millivolt, [range][step]
  localparam logic [1:0][7:0][9:0] LMR_OC_TAB = {
    {10'd750, 10'd696, 10'd643, 10'd589, 10'd536, 10'd482, 10'd429, 10'd375},
    {10'd500, 10'd464, 10'd429, 10'd393, 10'd357, 10'd321, 10'd286, 10'd250}};
  localparam longint LMR_ABS_ZERO_CENTI = -27315;
  localparam longint LMR_ABS_ZERO_Q8 = LMR_ABS_ZERO_CENTI * 256 / 100;
  localparam longint LMR_TC_NOM_C = 27;
  localparam longint LMR_TC_NOM_Q8 = LMR_TC_NOM_C * 256;
  localparam longint LMR_PPM_DIV = 1000000;
  localparam int LMR_SLOPE_SHIFT = 14;
  localparam logic signed [15:0] LMR_SLOPE_MIN = 16'sh2000;
  localparam longint LMR_RISE_BYPASS_US = 250;
  localparam longint LMR_RISE_BYPASS_Q8 = LMR_RISE_BYPASS_US * 256 / 1000;
  localparam longint LMR_SLOPE_MAX_MV_PER_MS = 4000;
  localparam longint LMR_SLOPE_MAX_Q8 = LMR_SLOPE_MAX_MV_PER_MS * 256;
  localparam longint LMR_MV_PER_V = 1000;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned LMR_CLK_PERIOD_NS = 8;
  localparam int unsigned LMR_MS_NS = 1000000;
  localparam int unsigned LMR_MS_CYCLES = LMR_MS_NS / LMR_CLK_PERIOD_NS;
  localparam int unsigned LMR_RESP_MAX_MS = 90;
  localparam logic [31:0] LMR_MS_Q8 = 32'h0000_0100;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LMR_SEQ_OFF, LMR_SEQ_DELAY, LMR_SEQ_RISE, LMR_SEQ_ON} lmr_seq_t;
  typedef struct packed {
    logic start;
    logic ramp_down;
    logic peak_limit;
    logic above_uv;
    logic high_range;
    logic [15:0] current_sense_gain;
    logic [15:0] sense_gain_temp_coefficient;
    logic [15:0] average_output_current_reading;
    logic signed [31:0] temp_sense_q8;
    logic [15:0] output_voltage_setpoint;
  } lmr_chan_in_t;
  typedef struct packed {
    logic dcm;
    logic rise_bypass;
    logic oc_fault;
    logic ot_fault;
    logic ut_fault;
    logic ton_max_fault;
    logic [9:0] oc_thresh;
    logic [31:0] ref_q8;
    logic signed [31:0] ext_temp_q8;
  } lmr_chan_out_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [7:0] page;
    logic [15:0] wdata;
  } lmr_host_req_t;
  typedef struct packed {
    logic rvalid;
    logic nack;
    logic [15:0] rdata;
  } lmr_host_rsp_t;
  typedef struct packed {
    lmr_seq_t seq;
    logic [31:0] cnt_q8;
    logic [31:0] ton_q8;
    logic [31:0] step_q8;
    logic [31:0] ref_q8;
    logic signed [31:0] ext_temp_q8;
    logic [9:0] oc_thresh;
    logic [7:0] output_current_status;
    logic [7:0] status_temp;
    logic ton_fault;
    logic bypass;
    logic [10:0][15:0] regs;
  } lmr_chan_st_t;
  typedef struct packed {
    logic [16:0] div_cnt;
    lmr_host_rsp_t rsp;
    logic [1:0][$bits(lmr_chan_st_t)-1:0] ch;
  } lmr_state_t;

  // Two-byte word: 5-bit signed exponent, 11-bit signed mantissa, to Q8
  function automatic logic signed [63:0] lmr_lin_q8(input logic [15:0] w);
    logic signed [5:0] e;
    logic signed [63:0] m;
    e = $signed({w[15], w[15:11]}) + 6'sd8;
    m = 64'($signed(w[10:0]));
    if (e >= 0) begin
      lmr_lin_q8 = m <<< e;
    end else begin
      lmr_lin_q8 = m >>> (-e);
    end
  endfunction : lmr_lin_q8
endpackage : lmr_pkg
`default_nettype wire

// ### lmr_host_model.sv
// Host model of the paged command port, one word access at a time.
// Assumes the bank answers on the same edge that it takes a strobe.
`default_nettype none
module lmr_host_model (
  input wire logic ref_clk,
  output var lmr_pkg::lmr_host_req_t host_req,
  input wire lmr_pkg::lmr_host_rsp_t host_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_req = '0;
  // Idle fields show the inverse so a stale word never passes for a fresh one
  task automatic acc(input logic w, input logic [7:0] c, input logic [7:0] p,
      input logic [15:0] d, output logic [15:0] q, output logic nk);
    @(posedge ref_clk);
    host_req <= '{wr: w, rd: !w, cmd: c, page: p, wdata: d};
    @(posedge ref_clk);
    host_req <= '{wr: 1'b0, rd: 1'b0, cmd: ~c, page: ~p, wdata: ~d};
    #1;
    q = host_rsp.rdata;
    nk = host_rsp.nack;
  endtask : acc
endmodule : lmr_host_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the paged limit and ramp timing bank.
// Assumes a short ms tick so a default ramp ends in under 100 cycles.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic meas_valid = 1'b0;
  lmr_pkg::lmr_host_req_t host_req;
  lmr_pkg::lmr_host_rsp_t host_rsp;
  lmr_pkg::lmr_chan_in_t [1:0] ci = '0;
  lmr_pkg::lmr_chan_out_t [1:0] co;
  logic alert_out;
  logic alert_oe_n;
  logic [15:0] q;
  logic nk;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int n = 0;
  lmr_limit_monitor #(.MS_CYCLES(8)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .host_req(host_req), .host_rsp(host_rsp), .meas_valid(meas_valid), .chan_in(ci),
    .chan_out(co), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
  lmr_host_model host (.ref_clk(ref_clk), .host_req(host_req), .host_rsp(host_rsp));
  initial forever #4 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic meas(input int i, input logic [15:0] cur, input logic signed [31:0] t);
    @(posedge ref_clk);
    ci[i].average_output_current_reading <= cur;
    ci[i].temp_sense_q8 <= t;
    meas_valid <= 1'b1;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    #1;
  endtask : meas
  initial begin
    for (int i = 0; i < 2; i++) begin
      ci[i].current_sense_gain = 16'h0001;
      ci[i].above_uv = 1'b1;
      ci[i].output_voltage_setpoint = 16'h03E8;
      ci[i].temp_sense_q8 = 32'sh00012C00;
    end
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int r = 0; r < lmr_pkg::LMR_NREG; r++) begin
      host.acc(1'b0, lmr_pkg::LMR_CMD_CODES[r], 8'h01, 16'h0000, q, nk);
      chk("reset value", 32'(lmr_pkg::LMR_RESET_VALS[r]), 32'(q));
    end
    host.acc(1'b1, 8'h53, 8'h01, 16'h06ED, q, nk);
    host.acc(1'b0, 8'h53, 8'h01, 16'h0000, q, nk);
    chk("ut limit page 1", 32'h06ED, 32'(q));
    host.acc(1'b0, 8'h53, 8'h00, 16'h0000, q, nk);
    chk("ut limit page 0", 32'hE580, 32'(q));
    host.acc(1'b0, 8'h53, 8'h02, 16'h0000, q, nk);
    chk("bad page nack", 32'h1, 32'(nk));
    chk("low range step", 32'd321, 32'(co[0].oc_thresh));
    @(posedge ref_clk);
    ci[0].high_range <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("high range step", 32'd375, 32'(co[0].oc_thresh));
    meas(0, 16'h0019, 32'sh00012C00);
    chk("alert on warn", 32'h0, 32'(alert_oe_n));
    host.acc(1'b0, 8'h7B, 8'h00, 16'h0000, q, nk);
    chk("iout warn bit", 32'h20, 32'(q & 16'h0020));
    host.acc(1'b0, 8'h78, 8'h00, 16'h0000, q, nk);
    chk("catch-all bit", 32'h1, 32'(q & 16'h0001));
    host.acc(1'b0, 8'h79, 8'h00, 16'h0000, q, nk);
    chk("word iout bit", 32'h4000, 32'(q & 16'h4000));
    host.acc(1'b1, 8'h7B, 8'h00, 16'h00FF, q, nk);
    meas(0, 16'h000A, 32'sh00012C00);
    chk("alert released", 32'h1, 32'(alert_oe_n));
    // 90 C on channel 1: above the warning, below the fault limit
    meas(1, 16'h0000, 32'sh00016B26);
    host.acc(1'b0, 8'h7D, 8'h01, 16'h0000, q, nk);
    chk("ot warn only", 32'h40, 32'(q & 16'h00C0));
    host.acc(1'b0, 8'h78, 8'h01, 16'h0000, q, nk);
    chk("temp byte bit", 32'h4, 32'(q & 16'h0004));
    // 110 C on channel 1 crosses the fault limit
    meas(1, 16'h0000, 32'sh00017F26);
    chk("ext temp", 32'(32'sh00017F26 + lmr_pkg::LMR_ABS_ZERO_Q8), co[1].ext_temp_q8);
    chk("ot fault", 32'h1, 32'(co[1].ot_fault));
    // -50 C on channel 0; channel 1 reads as if no sensor were fitted
    meas(0, 16'h0000, 32'sh0000DF26);
    chk("ut fault", 32'h1, 32'(co[0].ut_fault));
    meas(1, 16'h0000, 32'sh00000000);
    chk("ut fault unfitted", 32'h0, 32'(co[1].ut_fault));
    // -3900 ppm at -50 C lifts the limit by about 30 percent
    @(posedge ref_clk);
    ci[0].sense_gain_temp_coefficient <= 16'hF0C4;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("compensated step", 32'd429, 32'(co[0].oc_thresh));
    // Peak limit only once rising: in the off and delay states it would be a fault
    @(posedge ref_clk);
    ci[0].start <= 1'b1;
    ci[1].start <= 1'b1;
    ci[1].above_uv <= 1'b0;
    while (co[0].dcm !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    ci[0].peak_limit <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("no oc fault in rise", 32'h0, 32'(co[0].oc_fault));
    while (co[0].dcm === 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    repeat (2) @(posedge ref_clk);
    #1;
    chk("ref at setpoint", 32'h0003E800, co[0].ref_q8);
    chk("oc fault in limit", 32'h1, 32'(co[0].oc_fault));
    chk("no bypass", 32'h0, 32'(co[0].rise_bypass));
    chk("alert data low", 32'h0, 32'(alert_out));
    // Channel 1 never gets above undervoltage: its 10 ms limit runs out
    repeat (30) @(posedge ref_clk);
    #1;
    chk("turn-on timeout", 32'h1, 32'(co[1].ton_max_fault));
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
